// ==== design/lfsc_ramp.v ====
// ramp generator moving an 8-bit drive level toward on or off
`timescale 1ns/1ps
`default_nettype none

module lfsc_ramp (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // control
  input wire i_target,
  input wire i_instant,
  input wire [31:0] i_step_cycles,
  // level
  output reg [7:0] o_level
);

  reg [31:0] cnt_reg;

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_reg <= 32'h0;
      o_level <= 8'h00;
    end else if (i_instant) begin
      cnt_reg <= 32'h0;
      o_level <= i_target ? 8'hff : 8'h00;
    end else if ((i_target && o_level != 8'hff) ||
                 (!i_target && o_level != 8'h00)) begin
      if (cnt_reg + 32'h1 >= i_step_cycles) begin
        cnt_reg <= 32'h0;
        o_level <= i_target ? o_level + 8'h01 : o_level - 8'h01;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end else begin
      cnt_reg <= 32'h0;
    end
  end

endmodule // lfsc_ramp

`default_nettype wire

// ==== design/lfsc_regs.vh ====
// register offsets, field positions, reset values and timing for the sink control
`ifndef LFSC_REGS_VH
`define LFSC_REGS_VH

`define LFSC_ADDR_FLASH_CTRL 8'had
`define LFSC_ADDR_SINK_B 8'hae

`define LFSC_BIT_MODE 15
`define LFSC_BIT_TRIGSRC 14
`define LFSC_BIT_DRIVE 13
`define LFSC_BIT_REPEAT 12
`define LFSC_LEN_HI 9
`define LFSC_LEN_LO 8
`define LFSC_FALL_HI 5
`define LFSC_FALL_LO 4
`define LFSC_RISE_HI 1
`define LFSC_RISE_LO 0

`define LFSC_BIT_B_ENABLE 15
`define LFSC_BIT_B_SLEEP 12
`define LFSC_LEVEL_HI 5
`define LFSC_LEVEL_LO 0

`define LFSC_RST_BIT 1'b0
`define LFSC_RST_FIELD2 2'h0
`define LFSC_RST_LEVEL 6'h00

`define LFSC_CLK_MHZ 250
`define LFSC_FLASH_T0_US 32000
`define LFSC_FLASH_T1_US 64000
`define LFSC_FLASH_T2_US 96000
`define LFSC_FLASH_T3_US 1024000
`define LFSC_LED_RAMP1_US 250000
`define LFSC_LED_RAMP2_US 500000
`define LFSC_LED_RAMP3_US 1000000
`define LFSC_FL_RAMP1_US 1950
`define LFSC_FL_RAMP2_US 3910
`define LFSC_FL_RAMP3_US 7800
`define LFSC_REPEAT_US 4000000
`define LFSC_RAMP_STEPS 255

`endif

// ==== design/lfsc_top.v ====
// sink A flash and LED control with sink B driver register
//
// Overview of operation
// - bit 15 selects LED or flash mode
// - bit 14 picks register or GPIO trigger
// - trigger source ignored in LED mode
// - LED mode: drive bit turns sink on/off
// - drive rising starts flash, self-clears at end
// - GPIO source: drive writes do not trigger
// - repeat bit retriggers flash every 4 seconds
// - bits 9:8 set flash length
// - bits 5:4 set switch-off ramp time
// - bits 1:0 set switch-on ramp, 00 instant
// - sink B enable bit 15
// - sink B hibernate behaviour bit 12
// - sink B six-bit level code, reset zero
// - power state machine reset restores all defaults
// - sink A runs only with its enable
`timescale 1ns/1ps
`default_nettype none
`include "lfsc_regs.vh"

module lfsc_top #(
  parameter [0:0] DRIVE_DEFAULT = 1'b0,
  parameter [31:0] FLASH_CYC0 = `LFSC_FLASH_T0_US * `LFSC_CLK_MHZ,
  parameter [31:0] FLASH_CYC1 = `LFSC_FLASH_T1_US * `LFSC_CLK_MHZ,
  parameter [31:0] FLASH_CYC2 = `LFSC_FLASH_T2_US * `LFSC_CLK_MHZ,
  parameter [31:0] FLASH_CYC3 = `LFSC_FLASH_T3_US * `LFSC_CLK_MHZ,
  parameter [31:0] LED_RAMP_CYC1 = `LFSC_LED_RAMP1_US * `LFSC_CLK_MHZ,
  parameter [31:0] LED_RAMP_CYC2 = `LFSC_LED_RAMP2_US * `LFSC_CLK_MHZ,
  parameter [31:0] LED_RAMP_CYC3 = `LFSC_LED_RAMP3_US * `LFSC_CLK_MHZ,
  parameter [31:0] FL_RAMP_CYC1 = `LFSC_FL_RAMP1_US * `LFSC_CLK_MHZ,
  parameter [31:0] FL_RAMP_CYC2 = `LFSC_FL_RAMP2_US * `LFSC_CLK_MHZ,
  parameter [31:0] FL_RAMP_CYC3 = `LFSC_FL_RAMP3_US * `LFSC_CLK_MHZ,
  parameter [31:0] REPEAT_CYC = `LFSC_REPEAT_US * `LFSC_CLK_MHZ
) (
  // clock and power state machine reset
  input wire i_clk,
  input wire i_rst_b,
  // register port
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  // system inputs
  input wire i_sink_a_enable,
  input wire i_gpio_flash,
  input wire i_hibernate,
  // sink A
  output reg o_sink_a_pin,
  output wire [7:0] o_sink_a_level,
  output reg o_flash_active,
  // sink B
  output reg o_sink_b_pin,
  output reg [5:0] o_sink_b_output
);

  localparam [31:0] STEPS = `LFSC_RAMP_STEPS;

  // ---------------------------------------------------------------
  // duration decode
  // ---------------------------------------------------------------
  function [31:0] lfsc_ramp_cycles;
    input flash_mode;
    input [1:0] code;
    begin
      case (code)
        2'h1: lfsc_ramp_cycles = flash_mode ? FL_RAMP_CYC1 : LED_RAMP_CYC1;
        2'h2: lfsc_ramp_cycles = flash_mode ? FL_RAMP_CYC2 : LED_RAMP_CYC2;
        2'h3: lfsc_ramp_cycles = flash_mode ? FL_RAMP_CYC3 : LED_RAMP_CYC3;
        default: lfsc_ramp_cycles = 32'h1;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg sink_a_mode_select_reg;
  reg sink_a_trigger_source_reg;
  reg sink_a_drive_trigger_reg;
  reg sink_a_repeat_select_reg;
  reg [1:0] sink_a_flash_length_reg;
  reg [1:0] sink_a_fall_ramp_reg;
  reg [1:0] sink_a_rise_ramp_reg;
  reg sink_b_enable_reg;
  reg sink_b_sleep_behaviour_reg;
  reg [5:0] sink_b_level_code_reg;
  reg gpio_prev_reg;
  reg [31:0] flash_cnt_reg;
  reg [31:0] flash_len_reg;
  reg [31:0] repeat_cnt_reg;

  wire wr_a = i_reg_wr && (i_reg_addr == `LFSC_ADDR_FLASH_CTRL);
  wire wr_b = i_reg_wr && (i_reg_addr == `LFSC_ADDR_SINK_B);
  wire wr_drive = i_reg_wdata[`LFSC_BIT_DRIVE];
  wire flash_mode = sink_a_mode_select_reg;
  wire use_gpio = sink_a_trigger_source_reg;
  wire flash_end = o_flash_active && (flash_cnt_reg + 32'h1 >= flash_len_reg);
  wire repeat_fire = flash_mode && sink_a_repeat_select_reg &&
                     (repeat_cnt_reg + 32'h1 >= REPEAT_CYC);
  wire reg_trig = flash_mode && !use_gpio && wr_a &&
                  wr_drive && !sink_a_drive_trigger_reg;
  wire gpio_trig = flash_mode && use_gpio && i_gpio_flash && !gpio_prev_reg;
  wire start = !o_flash_active && (reg_trig || gpio_trig || repeat_fire);
  reg [31:0] len_sel;

  always @* begin
    case (sink_a_flash_length_reg)
      2'h0: len_sel = FLASH_CYC0;
      2'h1: len_sel = FLASH_CYC1;
      2'h2: len_sel = FLASH_CYC2;
      default: len_sel = FLASH_CYC3;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sink_a_mode_select_reg <= `LFSC_RST_BIT;
      sink_a_trigger_source_reg <= `LFSC_RST_BIT;
      sink_a_drive_trigger_reg <= DRIVE_DEFAULT;
      sink_a_repeat_select_reg <= `LFSC_RST_BIT;
      sink_a_flash_length_reg <= `LFSC_RST_FIELD2;
      sink_a_fall_ramp_reg <= `LFSC_RST_FIELD2;
      sink_a_rise_ramp_reg <= `LFSC_RST_FIELD2;
      sink_b_enable_reg <= `LFSC_RST_BIT;
      sink_b_sleep_behaviour_reg <= `LFSC_RST_BIT;
      sink_b_level_code_reg <= `LFSC_RST_LEVEL;
    end else begin
      if (wr_a) begin
        sink_a_mode_select_reg <= i_reg_wdata[`LFSC_BIT_MODE];
        sink_a_trigger_source_reg <= i_reg_wdata[`LFSC_BIT_TRIGSRC];
        sink_a_repeat_select_reg <= i_reg_wdata[`LFSC_BIT_REPEAT];
        sink_a_flash_length_reg <=
          i_reg_wdata[`LFSC_LEN_HI:`LFSC_LEN_LO];
        sink_a_fall_ramp_reg <= i_reg_wdata[`LFSC_FALL_HI:`LFSC_FALL_LO];
        sink_a_rise_ramp_reg <= i_reg_wdata[`LFSC_RISE_HI:`LFSC_RISE_LO];
      end
      // software write wins over the end-of-flash self clear
      if (wr_a)
        sink_a_drive_trigger_reg <= wr_drive;
      else if (flash_end && flash_mode && !use_gpio)
        sink_a_drive_trigger_reg <= 1'b0;
      if (wr_b) begin
        sink_b_enable_reg <= i_reg_wdata[`LFSC_BIT_B_ENABLE];
        sink_b_sleep_behaviour_reg <= i_reg_wdata[`LFSC_BIT_B_SLEEP];
        sink_b_level_code_reg <=
          i_reg_wdata[`LFSC_LEVEL_HI:`LFSC_LEVEL_LO];
      end
    end
  end

  // ---------------------------------------------------------------
  // flash sequencer
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      gpio_prev_reg <= 1'b0;
      o_flash_active <= 1'b0;
      flash_cnt_reg <= 32'h0;
      flash_len_reg <= 32'h1;
      repeat_cnt_reg <= 32'h0;
    end else begin
      gpio_prev_reg <= i_gpio_flash;
      if (!flash_mode || !sink_a_repeat_select_reg || repeat_fire)
        repeat_cnt_reg <= 32'h0;
      else
        repeat_cnt_reg <= repeat_cnt_reg + 32'h1;
      if (!flash_mode) begin
        o_flash_active <= 1'b0;
        flash_cnt_reg <= 32'h0;
      end else if (start) begin
        o_flash_active <= 1'b1;
        flash_cnt_reg <= 32'h0;
        flash_len_reg <= len_sel;
      end else if (flash_end) begin
        o_flash_active <= 1'b0;
        flash_cnt_reg <= 32'h0;
      end else if (o_flash_active) begin
        flash_cnt_reg <= flash_cnt_reg + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // sink outputs and readback
  // ---------------------------------------------------------------
  wire a_target = flash_mode ? o_flash_active : sink_a_drive_trigger_reg;
  wire [1:0] ramp_code = a_target ? sink_a_rise_ramp_reg :
                                    sink_a_fall_ramp_reg;
  wire [31:0] ramp_cyc = lfsc_ramp_cycles(flash_mode, ramp_code);
  wire [31:0] step_cyc = ramp_cyc / STEPS;

  lfsc_ramp u_ramp (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_target(o_sink_a_pin),
    .i_instant(ramp_code == 2'h0),
    .i_step_cycles(step_cyc),
    .o_level(o_sink_a_level)
  );

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sink_a_pin <= 1'b0;
      o_sink_b_pin <= 1'b0;
      o_sink_b_output <= `LFSC_RST_LEVEL;
      o_reg_rdata <= 16'h0000;
    end else begin
      o_sink_a_pin <= i_sink_a_enable && a_target;
      o_sink_b_pin <= sink_b_enable_reg &&
                      (!i_hibernate || sink_b_sleep_behaviour_reg);
      o_sink_b_output <= sink_b_level_code_reg;
      if (i_reg_rd) begin
        if (i_reg_addr == `LFSC_ADDR_FLASH_CTRL)
          o_reg_rdata <= {sink_a_mode_select_reg, sink_a_trigger_source_reg,
                          sink_a_drive_trigger_reg, sink_a_repeat_select_reg,
                          2'h0, sink_a_flash_length_reg, 2'h0,
                          sink_a_fall_ramp_reg, 2'h0, sink_a_rise_ramp_reg};
        else if (i_reg_addr == `LFSC_ADDR_SINK_B)
          o_reg_rdata <= {sink_b_enable_reg, 2'h0,
                          sink_b_sleep_behaviour_reg, 6'h00,
                          sink_b_level_code_reg};
        else
          o_reg_rdata <= 16'h0000;
      end
    end
  end

endmodule // lfsc_top

`default_nettype wire

// ==== test/lfsc_led_model.sv ====
// led string model measuring cycles between switch-on edges
`timescale 1ns/1ps
`default_nettype none
module lfsc_led_model (
  // sink drive from the block
  input wire logic i_clk,
  input wire logic i_pin,
  // cycles between the last two light-up edges
  output logic [31:0] o_gap,
  // cycles the string stayed lit in its last finished pulse
  output logic [31:0] o_lit
);
  logic [31:0] t = 32'h0;
  logic [31:0] w = 32'h0;
  logic last = 1'b0;
  initial o_gap = 32'h0;
  initial o_lit = 32'h0;
  always @(posedge i_clk) begin
    t <= (i_pin & ~last) ? 32'h1 : t + 32'h1;
    if (i_pin & ~last) o_gap <= t;
    w <= i_pin ? w + 32'h1 : 32'h0;
    if (~i_pin & last) o_lit <= w;
    last <= i_pin;
  end
endmodule // lfsc_led_model
`default_nettype wire

// ==== test/lfsc_properties.sv ====
// concurrent checks on the sink control ports
`timescale 1ns/1ps
`default_nettype none
module lfsc_properties #(
  parameter int F0 = 40,
  parameter int F1 = 80,
  parameter int F2 = 120,
  parameter int F3 = 200
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  // system inputs
  input wire logic i_sink_a_enable,
  input wire logic i_gpio_flash,
  input wire logic i_hibernate,
  // sink outputs
  input wire logic o_sink_a_pin,
  input wire logic [7:0] o_sink_a_level,
  input wire logic o_flash_active,
  input wire logic o_sink_b_pin,
  input wire logic [5:0] o_sink_b_output
);
  logic [15:0] fc, sb;
  logic [31:0] cnt;
  logic [1:0] lc;
  wire wa = i_reg_wr && i_reg_addr == 8'had;
  wire wb = i_reg_wr && i_reg_addr == 8'hae;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ----
  // shadow registers and flash length counter
  // ----
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      fc <= 16'h0000;
      sb <= 16'h0000;
      cnt <= 32'h0;
    end else begin
      if (wa) fc <= i_reg_wdata;
      if (wb) sb <= i_reg_wdata;
      cnt <= o_flash_active ? cnt + 32'h1 : 32'h0;
    end
    if (!o_flash_active) lc <= fc[9:8];
  end
  sequence s_b_write;
    wb ##1 !wb [*2];
  endsequence
  sequence s_gpio_rise;
    fc[15] && fc[14] && !o_flash_active ##0 $rose(i_gpio_flash);
  endsequence
  a_b_pin_state: assert property (
    o_sink_b_pin == $past(sb[15] & (!i_hibernate | sb[12])))
    else $error("sink b pin wrong");
  a_b_level_code: assert property (
    s_b_write |-> o_sink_b_output == $past(i_reg_wdata[5:0], 2))
    else $error("sink b level wrong");
  a_led_pin_follow: assert property (
    !fc[15] && !o_flash_active
    |=> o_sink_a_pin == $past(i_sink_a_enable && fc[13]))
    else $error("sink a pin wrong in led mode");
  a_flash_len_exact: assert property (
    $fell(o_flash_active) && fc[15]
    |-> cnt == (lc == 0 ? F0 : lc == 1 ? F1 : lc == 2 ? F2 : F3))
    else $error("flash length wrong");
  a_gpio_start_flash: assert property (
    s_gpio_rise |-> ##[1:2] o_flash_active)
    else $error("gpio edge did not flash");
  a_gpio_drive_ignored: assert property (
    fc[14] && !fc[12] && wa && i_reg_wdata[15:12] == 4'he
    && !o_flash_active && !i_gpio_flash && !$past(i_gpio_flash)
    |=> !o_flash_active)
    else $error("drive write flashed in gpio mode");
  a_ramp_on_instant: assert property (
    $rose(o_sink_a_pin) && fc[1:0] == 2'h0 |=> o_sink_a_level == 8'hff)
    else $error("instant switch-on too slow");
  a_led_no_flash: assert property (
    !fc[15] && !$past(fc[15]) |-> !o_flash_active)
    else $error("flash active in led mode");
endmodule // lfsc_properties
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the sink control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_errors++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  logic i_clk = 0, i_rst_b = 0, i_reg_wr = 0, i_reg_rd = 0, rd_d = 0;
  logic i_sink_a_enable = 0, i_gpio_flash = 0, i_hibernate = 0;
  logic [7:0] i_reg_addr = 8'h00, o_sink_a_level;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata, d, exp_rd, expq[$];
  logic o_sink_a_pin, o_flash_active, o_sink_b_pin;
  logic [5:0] o_sink_b_output;
  logic [31:0] gap, pulse_len;
  int n_errors = 0, samples_checked = 0, n;
  int lens[4] = '{40, 80, 120, 4000};
  // ramps keep their real timing; a 4000-cycle flash spans two ramp steps
  lfsc_top #(.FLASH_CYC0(40), .FLASH_CYC1(80), .FLASH_CYC2(120),
    .FLASH_CYC3(4000), .REPEAT_CYC(500)) u_dut (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_sink_a_enable(i_sink_a_enable),
    .i_gpio_flash(i_gpio_flash),
    .i_hibernate(i_hibernate),
    .o_sink_a_pin(o_sink_a_pin),
    .o_sink_a_level(o_sink_a_level),
    .o_flash_active(o_flash_active),
    .o_sink_b_pin(o_sink_b_pin),
    .o_sink_b_output(o_sink_b_output)
  );
  lfsc_led_model u_led (
    .i_clk(i_clk),
    .i_pin(o_sink_a_pin),
    .o_gap(gap),
    .o_lit(pulse_len)
  );
  initial forever #2 i_clk = ~i_clk;
  // ----
  // read monitor and bus tasks
  // ----
  always @(posedge i_clk) rd_d <= i_reg_rd;
  always @(negedge i_clk) if (rd_d) begin
    exp_rd = expq.pop_front();
    `CHK(o_reg_rdata, exp_rd)
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] v);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = w;
    i_reg_rd = !w;
    cyc(1);
    i_reg_wr = 0;
    i_reg_rd = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    acc(0, a, 16'h0000);
  endtask
  task automatic wait_fl(input logic v);
    n = 0;
    while (o_flash_active !== v && n < 5000) begin
      cyc(1);
      n++;
    end
    if (n == 5000) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // one whole flash, then two edges for the string model to report it
  task automatic fl_len();
    wait_fl(1);
    wait_fl(0);
    cyc(2);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(91));
    cyc(4);
    i_rst_b = 1;
    rd(8'had, 16'h0000);
    rd(8'hae, 16'h0000);
    rd(8'h00, 16'h0000);
    $display("reset test done");
    repeat (6) begin
      d = 16'($urandom);
      i_hibernate = 1'($urandom);
      acc(1, 8'hae, d);
      cyc(2);
      `CHK(o_sink_b_pin, d[15] & (!i_hibernate | d[12]))
      `CHK(o_sink_b_output, d[5:0])
      rd(8'hae, d & 16'h903f);
    end
    $display("sink b test done");
    for (int k = 0; k < 4; k++) begin
      i_sink_a_enable = k[0];
      i_gpio_flash = k[1];
      acc(1, 8'had, {2'b01, k[1], 13'h0000});
      cyc(2);
      `CHK(o_sink_a_pin, k[0] & k[1])
      `CHK(o_flash_active, 1'b0)
    end
    i_gpio_flash = 0;
    $display("led test done");
    for (int c = 0; c < 4; c++) begin
      d = 16'h8000 | (16'(c) << 8);
      acc(1, 8'had, d);
      acc(1, 8'had, d | 16'h2000);
      fl_len();
      `CHK(pulse_len, lens[c])
      rd(8'had, d);
    end
    $display("flash length test done");
    acc(1, 8'had, 16'hc000);
    acc(1, 8'had, 16'he000);
    cyc(4);
    `CHK(o_flash_active, 1'b0)
    i_gpio_flash = 1;
    fl_len();
    `CHK(pulse_len, 32'd40)
    i_gpio_flash = 0;
    cyc(2);
    i_gpio_flash = 1;
    wait_fl(1);
    cyc(20);
    i_gpio_flash = 0;
    cyc(1);
    i_gpio_flash = 1;
    cyc(25);
    `CHK(o_flash_active, 1'b0)
    $display("gpio test done");
    acc(1, 8'had, 16'h9000);
    cyc(1200);
    `CHK(gap, 32'd500)
    $display("repeat test done");
    acc(1, 8'had, 16'h8311);
    acc(1, 8'had, 16'ha311);
    wait_fl(1);
    cyc(2000);
    `CHK(o_sink_a_level > 8'h00 && o_sink_a_level < 8'hff, 1'b1)
    wait_fl(0);
    cyc(60);
    `CHK(o_sink_a_level > 8'h00 && o_sink_a_level < 8'hff, 1'b1)
    acc(1, 8'had, 16'ha311);
    wait_fl(1);
    i_rst_b = 0;
    cyc(2);
    i_rst_b = 1;
    `CHK(o_flash_active | o_sink_a_pin, 1'b0)
    rd(8'had, 16'h0000);
    cyc(2);
    $display("ramp and reset test done");
    report_and_stop();
  end
endmodule // testbench
bind lfsc_top lfsc_properties #(.F0(FLASH_CYC0), .F1(FLASH_CYC1),
  .F2(FLASH_CYC2), .F3(FLASH_CYC3)) u_props (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata),
  .i_sink_a_enable(i_sink_a_enable),
  .i_gpio_flash(i_gpio_flash),
  .i_hibernate(i_hibernate),
  .o_sink_a_pin(o_sink_a_pin),
  .o_sink_a_level(o_sink_a_level),
  .o_flash_active(o_flash_active),
  .o_sink_b_pin(o_sink_b_pin),
  .o_sink_b_output(o_sink_b_output)
);
`default_nettype wire
